// file: hw/frt_timer.sv
// frt_timer: 16-bit free-running timer with two input-capture channels.
// assumes: byte register port, read data one cycle after the strobe.
//
// Summary of operation
// - sixteen-bit up-counter, wraps, byte halves visible
// - internal period 65536 ticks of 2/4/8
// - low byte write reloads FFFCh
// - counter resets to FFFCh
// - main and alternate views same count
// - high read buffers low byte until read
// - lone low read returns live byte
// - wrap FFFFh to 0000h sets wrap flag
// - wrap interrupt needs enable and clear mask
// - status read then main low clears wrap
// - alternate low access keeps wrap flag
// - counting continues in wait mode
// - halt freezes count, reset restarts it
// - select code 11 counts external pin
// - control bit picks external edge polarity
// - external edges synchronised to cpu clock
// - capture copies count into channel register
// - edge-select bit picks capture polarity
// - unbonded timer input reads as one
// - reduced build drops second capture channel
// - instances share nothing, count in step
// - capture sets flag, maskable interrupt
// - status read then capture low clears
// - capture high read blocks captures
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "frt_defines.svh"
module frt_timer #(
  parameter bit REDUCED     = 1'b0,
  parameter bit EXT_BONDED  = 1'b1,
  parameter bit CAP1_BONDED = 1'b1,
  parameter bit CAP2_BONDED = 1'b1
)
(
  input  wire logic       SYS_CLK_I,
  input  wire logic       RST_B_I,
  input  wire logic [3:0] REG_ADDR_I,
  input  wire logic [7:0] REG_WDATA_I,
  input  wire logic       REG_WR_I,
  input  wire logic       REG_RD_I,
  output logic      [7:0] REG_RDATA_O,
  input  wire logic       CPU_IMASK_I,
  input  wire logic       HALT_I,
  input  wire logic       EXT_TICK_PIN_I,
  input  wire logic       CAPTURE_PIN_ONE_I,
  input  wire logic       CAPTURE_PIN_TWO_I,
  output logic            TIMER_IRQ_O
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  localparam frt_pkg::frt_main_st_t MAIN_RST = '{count: `FRT_COUNT_RST, default: '0};

  frt_pkg::frt_main_st_t st_q;
  frt_pkg::frt_main_st_t st_d;
  logic                  tick;
  logic                  acc;
  logic                  wr_lo;
  logic                  rd_status;
  logic                  main_lo_acc;
  logic                  alt_lo_acc;
  logic                  cnt_hi_rd;
  logic                  cnt_lo_rd;
  logic                  wrap_set;
  logic [1:0]            cap_hit;
  logic [1:0]            cap_set;
  logic [1:0]            cap_hi_rd;
  logic [1:0]            cap_lo_rd;
  logic [1:0]            cap_lo_acc;
  logic [2:0]            status;
  logic [1:0]            pins;

  frt_cap_if cap_if[2] ();

  // ****************************************************************
  // tick source
  // ****************************************************************
  frt_prescale #(
    .EXT_BONDED (EXT_BONDED)
  ) u_prescale (
    .sys_clk_i  (SYS_CLK_I),
    .rst_b_i    (RST_B_I),
    .sel_i      (frt_pkg::frt_tick_sel_t'(st_q.ctrl_two[1:0])),
    .ext_edge_i (st_q.ctrl_two[`FRT_C2_EXT_EDGE]),
    .ext_pin_i  (EXT_TICK_PIN_I),
    .halt_i     (HALT_I),
    .tick_o     (tick)
  );

  // ****************************************************************
  // capture channels
  // ****************************************************************
  assign pins   = {CAPTURE_PIN_TWO_I, CAPTURE_PIN_ONE_I};
  assign cap_if[0].edge_sel = st_q.ctrl_one[`FRT_C1_CAP1_EDGE];
  assign cap_if[1].edge_sel = st_q.ctrl_two[`FRT_C2_CAP2_EDGE];

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_cap
      if (g == 1 && REDUCED)
      begin : g_absent
        assign cap_if[g].evt = 1'b0;
      end
      else
      begin : g_chan
        frt_capture #(
          .BONDED    (g == 0 ? CAP1_BONDED : CAP2_BONDED)
        ) u_capture (
          .sys_clk_i (SYS_CLK_I),
          .rst_b_i   (RST_B_I),
          .pin_i     (pins[g]),
          .cap       (cap_if[g])
        );
      end
      assign cap_hit[g]    = cap_if[g].evt;
      assign cap_hi_rd[g]  = REG_RD_I && (REG_ADDR_I == (g == 0 ? `FRT_OFS_CAP1_HI
                                                                 : `FRT_OFS_CAP2_HI));
      assign cap_lo_rd[g]  = REG_RD_I && (REG_ADDR_I == (g == 0 ? `FRT_OFS_CAP1_LO
                                                                 : `FRT_OFS_CAP2_LO));
      assign cap_lo_acc[g] = acc && (REG_ADDR_I == (g == 0 ? `FRT_OFS_CAP1_LO
                                                           : `FRT_OFS_CAP2_LO));
      assign cap_set[g]    = cap_hit[g] && !st_q.cap_block[g];
    end
  endgenerate

  // ****************************************************************
  // access decode
  // ****************************************************************
  assign acc         = REG_RD_I || REG_WR_I;
  assign rd_status   = REG_RD_I && (REG_ADDR_I == `FRT_OFS_STATUS);
  assign main_lo_acc = acc && (REG_ADDR_I == `FRT_OFS_CNT_LO);
  assign alt_lo_acc  = acc && (REG_ADDR_I == `FRT_OFS_ALT_LO);
  assign wr_lo       = REG_WR_I && (REG_ADDR_I == `FRT_OFS_CNT_LO
                                    || REG_ADDR_I == `FRT_OFS_ALT_LO);
  assign cnt_hi_rd   = REG_RD_I && (REG_ADDR_I == `FRT_OFS_CNT_HI
                                    || REG_ADDR_I == `FRT_OFS_ALT_HI);
  assign cnt_lo_rd   = REG_RD_I && (REG_ADDR_I == `FRT_OFS_CNT_LO
                                    || REG_ADDR_I == `FRT_OFS_ALT_LO);
  assign wrap_set    = tick && !wr_lo && (st_q.count == `FRT_COUNT_TOP);
  assign status      = {st_q.cap_flag, st_q.wrap_flag};

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    st_d = st_q;
    st_d.rdata = 8'h00;
    // counter
    if (wr_lo)
      st_d.count = `FRT_COUNT_RST;
    else if (tick)
      st_d.count = st_q.count + 16'h0001;
    // wrap flag, set wins over clear
    if (rd_status && st_q.wrap_flag)
      st_d.wrap_armed = 1'b1;
    if (main_lo_acc && st_q.wrap_armed)
    begin
      st_d.wrap_flag  = 1'b0;
      st_d.wrap_armed = 1'b0;
    end
    if (wrap_set)
      st_d.wrap_flag = 1'b1;
    // capture channels
    for (int i = 0; i < 2; i++)
    begin
      if (rd_status && st_q.cap_flag[i])
        st_d.cap_armed[i] = 1'b1;
      if (cap_lo_acc[i] && st_q.cap_armed[i])
      begin
        st_d.cap_flag[i]  = 1'b0;
        st_d.cap_armed[i] = 1'b0;
      end
      if (cap_hi_rd[i])
        st_d.cap_block[i] = 1'b1;
      if (cap_lo_rd[i])
        st_d.cap_block[i] = 1'b0;
      if (cap_set[i])
      begin
        st_d.cap_val[i]  = st_q.count;
        st_d.cap_flag[i] = 1'b1;
      end
    end
    // counter read sequence
    if (cnt_hi_rd && !st_q.buf_valid)
    begin
      st_d.lo_buf    = st_q.count[7:0];
      st_d.buf_valid = 1'b1;
    end
    if (cnt_lo_rd)
      st_d.buf_valid = 1'b0;
    // control writes
    if (REG_WR_I && REG_ADDR_I == `FRT_OFS_CTRL_ONE)
      st_d.ctrl_one = REG_WDATA_I[2:0];
    if (REG_WR_I && REG_ADDR_I == `FRT_OFS_CTRL_TWO)
      st_d.ctrl_two = REG_WDATA_I[3:0];
    // read data
    if (REG_RD_I)
    begin
      case (REG_ADDR_I)
        `FRT_OFS_CTRL_TWO: st_d.rdata = {4'h0, st_q.ctrl_two};
        `FRT_OFS_CTRL_ONE: st_d.rdata = {5'h00, st_q.ctrl_one};
        `FRT_OFS_STATUS:   st_d.rdata = {5'h00, status};
        `FRT_OFS_CAP1_HI:  st_d.rdata = st_q.cap_val[0][15:8];
        `FRT_OFS_CAP1_LO:  st_d.rdata = st_q.cap_val[0][7:0];
        `FRT_OFS_CAP2_HI:  st_d.rdata = st_q.cap_val[1][15:8];
        `FRT_OFS_CAP2_LO:  st_d.rdata = st_q.cap_val[1][7:0];
        `FRT_OFS_CNT_HI,
        `FRT_OFS_ALT_HI:   st_d.rdata = st_q.count[15:8];
        `FRT_OFS_CNT_LO,
        `FRT_OFS_ALT_LO:   st_d.rdata = st_q.buf_valid ? st_q.lo_buf : st_q.count[7:0];
        default:           st_d.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_B_I)
      st_q <= MAIN_RST;
    else
      st_q <= st_d;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign REG_RDATA_O = st_q.rdata;
  // pending requests wait for enable and mask
  assign TIMER_IRQ_O = !CPU_IMASK_I
                       && ((st_q.wrap_flag && st_q.ctrl_one[`FRT_C1_WRAP_IE])
                           || (|st_q.cap_flag && st_q.ctrl_one[`FRT_C1_CAP_IE]));

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_div8_gap;
    (!tick) [*7] ##1 tick;
  endsequence

  sequence s_wrap_arm;
    rd_status && st_q.wrap_flag && !wrap_set;
  endsequence

  sequence s_wrap_take;
    main_lo_acc && !wrap_set;
  endsequence

  property p_reload;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    wr_lo |=> st_q.count == `FRT_COUNT_RST;
  endproperty
  a_reload: assert property (p_reload) else $error("low write did not reload");

  property p_count_step;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    (tick && !wr_lo) |=> st_q.count == $past(st_q.count) + 16'h0001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step");

  property p_div8;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I || HALT_I || REG_WR_I)
    (st_q.ctrl_two[1:0] == 2'b10 && tick) |=> s_div8_gap;
  endproperty
  a_div8: assert property (p_div8) else $error("divide by eight spacing wrong");

  property p_wrap_set;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    wrap_set |=> st_q.wrap_flag && st_q.count == 16'h0000;
  endproperty
  a_wrap_set: assert property (p_wrap_set) else $error("wrap did not set flag");

  property p_irq;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    (st_q.wrap_flag && st_q.ctrl_one[0] && !CPU_IMASK_I) |-> TIMER_IRQ_O;
  endproperty
  a_irq: assert property (p_irq) else $error("wrap request not raised");

  property p_irq_mask;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    CPU_IMASK_I |-> !TIMER_IRQ_O;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("request raised while masked");

  property p_wrap_clear;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    s_wrap_arm ##[1:4] s_wrap_take |=> !st_q.wrap_flag;
  endproperty
  a_wrap_clear: assert property (p_wrap_clear) else $error("wrap flag not cleared");

  property p_wrap_keep;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    (st_q.wrap_flag && !st_q.wrap_armed && main_lo_acc) |=> st_q.wrap_flag;
  endproperty
  a_wrap_keep: assert property (p_wrap_keep) else $error("unarmed access cleared flag");

  property p_alt_keep;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    (st_q.wrap_flag && alt_lo_acc) |=> st_q.wrap_flag;
  endproperty
  a_alt_keep: assert property (p_alt_keep) else $error("alternate access cleared flag");

  property p_buf_hold;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    (st_q.buf_valid && cnt_hi_rd) |=> $stable(st_q.lo_buf) && st_q.buf_valid;
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("low buffer changed");

  property p_live_lo;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    (cnt_lo_rd && !st_q.buf_valid) |=> REG_RDATA_O == $past(st_q.count[7:0]);
  endproperty
  a_live_lo: assert property (p_live_lo) else $error("lone low read not live");

  property p_halt;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    (HALT_I && !wr_lo) |=> $stable(st_q.count);
  endproperty
  a_halt: assert property (p_halt) else $error("count moved in halt");

  property p_capture;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    cap_set[0] |=> st_q.cap_val[0] == $past(st_q.count) && st_q.cap_flag[0];
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_cap_block;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    (|(st_q.cap_block & cap_hit)) |=> $stable(st_q.cap_val);
  endproperty
  a_cap_block: assert property (p_cap_block) else $error("blocked channel captured");

endmodule
`default_nettype wire

// file: hw/frt_defines.svh
// frt_defines.svh: register offsets, field positions, reset values and
// divider figures of the free-running timer.
// assumes: included by bare name from the timer and prescaler source files.
`ifndef FRT_DEFINES_SVH
`define FRT_DEFINES_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define FRT_OFS_CTRL_TWO     4'h0
`define FRT_OFS_CTRL_ONE     4'h1
`define FRT_OFS_STATUS       4'h2
`define FRT_OFS_CAP1_HI      4'h3
`define FRT_OFS_CAP1_LO      4'h4
`define FRT_OFS_CAP2_HI      4'h5
`define FRT_OFS_CAP2_LO      4'h6
`define FRT_OFS_CNT_HI       4'h7
`define FRT_OFS_CNT_LO       4'h8
`define FRT_OFS_ALT_HI       4'h9
`define FRT_OFS_ALT_LO       4'hA

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define FRT_C1_WRAP_IE       0
`define FRT_C1_CAP_IE        1
`define FRT_C1_CAP1_EDGE     2
`define FRT_C2_EXT_EDGE      2
`define FRT_C2_CAP2_EDGE     3
`define FRT_ST_WRAP          0
`define FRT_ST_CAP1          1
`define FRT_ST_CAP2          2
`define FRT_COUNT_RST        16'hFFFC
`define FRT_COUNT_TOP        16'hFFFF
`define FRT_DIV4_MASK        3'h3
`define FRT_DIV8_MASK        3'h7

`endif

// file: hw/frt_pkg.sv
// frt_pkg: types shared by the free-running timer modules.
// assumes: nothing beyond a SystemVerilog compiler.
package frt_pkg;

  // ****************************************************************
  // tick source codes
  // ****************************************************************
  typedef enum logic [1:0]
  {
    FRT_DIV2 = 2'b00,
    FRT_DIV4 = 2'b01,
    FRT_DIV8 = 2'b10,
    FRT_EXT  = 2'b11
  } frt_tick_sel_t;

  // ****************************************************************
  // module state records
  // ****************************************************************
  typedef struct packed {
    logic [2:0] div;
    logic [1:0] sync;
    logic       prev;
  } frt_pre_st_t;

  typedef struct packed {
    logic [1:0] sync;
    logic       prev;
  } frt_cap_st_t;

  typedef struct packed {
    logic [15:0]      count;
    logic [7:0]       rdata;
    logic [7:0]       lo_buf;
    logic             buf_valid;
    logic [3:0]       ctrl_two;
    logic [2:0]       ctrl_one;
    logic             wrap_flag;
    logic             wrap_armed;
    logic [1:0]       cap_flag;
    logic [1:0]       cap_armed;
    logic [1:0]       cap_block;
    logic [1:0][15:0] cap_val;
  } frt_main_st_t;

endpackage

// file: hw/frt_cap_if.sv
// frt_cap_if: edge select and capture event between timer and channel.
// assumes: one instance per capture channel.
`timescale 1ns/10ps
`default_nettype none
interface frt_cap_if;
  logic edge_sel;
  logic evt;
  modport host (output edge_sel, input evt);
  modport chan (input edge_sel, output evt);
endinterface
`default_nettype wire

// file: hw/frt_prescale.sv
// frt_prescale: tick generator, internal divider or external pin edge.
// assumes: SYS_CLK domain, synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
`include "frt_defines.svh"
module frt_prescale #(
  parameter bit EXT_BONDED = 1'b1
)
(
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_b_i,
  input  wire frt_pkg::frt_tick_sel_t sel_i,
  input  wire logic                 ext_edge_i,
  input  wire logic                 ext_pin_i,
  input  wire logic                 halt_i,
  output logic                      tick_o
);
  frt_pkg::frt_pre_st_t st_q;
  frt_pkg::frt_pre_st_t st_d;
  logic                 pin;
  logic                 ext_hit;

  assign pin = EXT_BONDED ? ext_pin_i : 1'b1;
  // external edge counted once it leaves the synchroniser
  assign ext_hit = ext_edge_i ? (st_q.sync[1] & ~st_q.prev) : (~st_q.sync[1] & st_q.prev);

  always_comb
  begin
    st_d = st_q;
    st_d.sync = {st_q.sync[0], pin};
    st_d.prev = st_q.sync[1];
    if (!halt_i)
    begin
      st_d.div = st_q.div + 3'h1;
    end
    unique case (sel_i)
      frt_pkg::FRT_DIV2: tick_o = st_q.div[0];
      frt_pkg::FRT_DIV4: tick_o = (st_q.div[1:0] == 2'(`FRT_DIV4_MASK)) ? 1'b1 : 1'b0;
      frt_pkg::FRT_DIV8: tick_o = (st_q.div == `FRT_DIV8_MASK) ? 1'b1 : 1'b0;
      frt_pkg::FRT_EXT:  tick_o = ext_hit;
    endcase
    tick_o = tick_o & ~halt_i;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
      // synchroniser follows the pin in reset, so no false edge after release
      st_q <= '{div: 3'h0, sync: {pin, pin}, prev: pin};
    else
      st_q <= st_d;
  end
endmodule
`default_nettype wire

// file: hw/frt_capture.sv
// frt_capture: capture pin synchroniser and active-edge detector.
// assumes: SYS_CLK domain, synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module frt_capture #(
  parameter bit BONDED = 1'b1
)
(
  input  wire logic sys_clk_i,
  input  wire logic rst_b_i,
  input  wire logic pin_i,
  frt_cap_if.chan   cap
);
  frt_pkg::frt_cap_st_t st_q;
  frt_pkg::frt_cap_st_t st_d;
  logic                 pin;

  assign pin = BONDED ? pin_i : 1'b1;

  always_comb
  begin
    st_d = st_q;
    st_d.sync = {st_q.sync[0], pin};
    st_d.prev = st_q.sync[1];
  end

  // one pulse per active transition
  assign cap.evt = cap.edge_sel ? (st_q.sync[1] & ~st_q.prev) : (~st_q.sync[1] & st_q.prev);

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
      // synchroniser follows the pin in reset, so no false capture after release
      st_q <= '{sync: {pin, pin}, prev: pin};
    else
      st_q <= st_d;
  end
endmodule
`default_nettype wire

// file: tb/frt_cpu_model.sv
// frt_cpu_model: byte-wide register master standing in for the cpu core.
// assumes: one clock; the bench top calls its tasks.
`timescale 1ns/10ps
`default_nettype none
module frt_cpu_model
(
  input  wire logic       sys_clk_i,
  output logic      [3:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o,
  input  wire logic [7:0] rdata_i
);
  // ****************************************************************
  // bus cycles: one-cycle strobes, released lines show inverted values
  // ****************************************************************
  initial
  begin
    addr_o  = 4'h0;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge sys_clk_i);
    addr_o  <= ~a;
    wdata_o <= ~d;
    wr_o    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge sys_clk_i);
    addr_o <= ~a;
    rd_o   <= 1'b0;
    #1 d = rdata_i;
  endtask
endmodule
`default_nettype wire

// file: tb/frt_timer_tb.sv
// frt_timer_tb: register-level tests of the free-running timer.
// assumes: frt_cpu_model drives the register port; halt freezes the count.
`timescale 1ns/10ps
`default_nettype none
module frt_timer_tb;
  logic        clk;
  logic        rst_b;
  logic        imask;
  logic        halt;
  logic        ext_pin;
  logic        cap_one;
  logic        cap_two;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        irq;
  logic [7:0]  junk;
  logic [15:0] cnt;
  logic [15:0] cnt_b;
  int          n_mismatch;
  int          comparisons;

  frt_timer dut (.SYS_CLK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .CPU_IMASK_I(imask), .HALT_I(halt),
    .EXT_TICK_PIN_I(ext_pin), .CAPTURE_PIN_ONE_I(cap_one), .CAPTURE_PIN_TWO_I(cap_two),
    .TIMER_IRQ_O(irq));
  frt_cpu_model cpu (.sys_clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
    .rdata_i(rdata));

  // ****************************************************************
  // clock, helpers and verdict
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic wrap_up;
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdb(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    cpu.rd_reg(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask

  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    logic [7:0] h;
    logic [7:0] l;
    cpu.rd_reg(a, h);
    cpu.rd_reg(a + 4'h1, l);
    v = {h, l};
  endtask

  task automatic run(input int n);
    @(posedge clk);
    halt <= 1'b0;
    repeat (n) @(posedge clk);
    halt <= 1'b1;
  endtask

  task automatic chk_irq(input logic e);
    repeat (8) @(posedge clk);
    #1 chk({15'h0000, irq}, {15'h0000, e});
  endtask

  task automatic tog_two;
    @(posedge clk);
    cap_two <= ~cap_two;
    repeat (8) @(posedge clk);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial
  begin
    rst_b = 1'b0;
    imask = 1'b1;
    halt = 1'b1;
    ext_pin = 1'b0;
    cap_one = 1'b0;
    cap_two = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rdb(4'h0, 8'h00);
    rdb(4'h1, 8'h00);
    rdb(4'h2, 8'h00);
    rdb(4'hF, 8'h00);
    rd16(4'h7, cnt);
    chk(cnt, 16'hFFFC);
    rd16(4'h9, cnt);
    chk(cnt, 16'hFFFC);
    rdb(4'h7, 8'hFF);
    run(100);
    cpu.wr_reg(4'h1, 8'h01);
    chk_irq(1'b0);
    @(posedge clk);
    imask <= 1'b0;
    chk_irq(1'b1);
    rdb(4'h7, 8'h00);
    rdb(4'h8, 8'hFC);
    rdb(4'h8, 8'h2E);
    chk_irq(1'b1);
    rdb(4'h2, 8'h01);
    rdb(4'hA, 8'h2E);
    chk_irq(1'b1);
    rdb(4'h8, 8'h2E);
    chk_irq(1'b0);
    rdb(4'h2, 8'h00);
    cpu.wr_reg(4'h7, 8'h55);
    rd16(4'h7, cnt);
    chk(cnt, 16'h002E);
    cpu.wr_reg(4'hA, 8'h55);
    rd16(4'h7, cnt);
    chk(cnt, 16'hFFFC);
    run(20);
    rd16(4'h9, cnt);
    chk(cnt, 16'h0006);
    cpu.wr_reg(4'h8, 8'h00);
    rd16(4'h7, cnt);
    chk(cnt, 16'hFFFC);
    for (int s = 0; s < 3; s++)
    begin
      cpu.wr_reg(4'h0, 8'(s));
      rd16(4'h7, cnt);
      run(64);
      rd16(4'h7, cnt_b);
      chk(cnt_b - cnt, 16'(64 >> (s + 1)));
    end
    for (int e = 1; e >= 0; e--)
    begin
      cpu.wr_reg(4'h0, {5'h00, e[0], 2'b11});
      rd16(4'h7, cnt);
      @(posedge clk);
      halt <= 1'b0;
      repeat (3)
      begin
        @(posedge clk);
        ext_pin <= ~ext_pin;
        repeat (8) @(posedge clk);
      end
      halt <= 1'b1;
      rd16(4'h7, cnt_b);
      chk(cnt_b - cnt, 16'h0002);
    end
    cpu.wr_reg(4'h0, 8'h00);
    cpu.wr_reg(4'h1, 8'h06);
    rd16(4'h7, cnt);
    @(posedge clk);
    cap_one <= 1'b1;
    chk_irq(1'b1);
    rdb(4'h2, 8'h03);
    rd16(4'h3, cnt_b);
    chk(cnt_b, cnt);
    rdb(4'h2, 8'h01);
    @(posedge clk);
    cap_one <= 1'b0;
    chk_irq(1'b0);
    cpu.rd_reg(4'h5, junk);
    repeat (2) tog_two();
    rdb(4'h2, 8'h01);
    cpu.rd_reg(4'h6, junk);
    repeat (2) tog_two();
    rdb(4'h2, 8'h05);
    rd16(4'h5, cnt_b);
    chk(cnt_b, cnt);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd16(4'h7, cnt);
    chk(cnt, 16'hFFFC);
    rdb(4'h2, 8'h00);
    rdb(4'h1, 8'h00);
    chk_irq(1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
